// ### common/fcl_defs.vh
// Limiter constants: offsets, limits, reset values, codes and timing counts.
// Assumes frequencies in 0.1 Hz units and voltage in volts.
// Contract
// (R1) Clamp command to programmed maximum, 0-120 Hz.
// (R2) High-speed and normal maximum stay linked.
// (R3) Hold output at minimum, default 0 Hz.
// (R4) Jog at or below minimum overrides minimum.
// (R5) Stall prevention may drop below minimum.
// (R6) Start alone ramps up to minimum.
// (R7) Three jump bands; 9999 disables, default.
// (R8) Inside a band run at first-of-pair.
// (R9) Band 30/35 holds 30; swapped gives 35.
// (R10) Ramping passes through bands, no skipping.
// (R11) Base frequency 0-400 Hz, default 60 Hz.
// (R12) Base voltage 0-1000 V; 8888, 9999 codes.
// (R13) Second select uses second base frequency.
// (R14) Third select uses third base frequency.
// (R15) Clamp first, then jump, then ramp.
`ifndef FCL_DEFS_VH
`define FCL_DEFS_VH

`define FCL_FW 16

`define FCL_OFS_MAX_FREQ    8'h00
`define FCL_OFS_MIN_FREQ    8'h04
`define FCL_OFS_HS_MAX_FREQ 8'h08
`define FCL_OFS_JOG_FREQ    8'h0c
`define FCL_OFS_START_FREQ  8'h10
`define FCL_OFS_JUMP_BASE   8'h14
`define FCL_OFS_BASE_FREQ   8'h2c
`define FCL_OFS_BASE_VOLT   8'h30
`define FCL_OFS_BASE2_FREQ  8'h34
`define FCL_OFS_BASE3_FREQ  8'h38
`define FCL_OFS_RAMP_STEP   8'h3c
`define FCL_OFS_STATUS      8'h40
`define FCL_OFS_BASE_STAT   8'h44

`define FCL_MAX_LIMIT       16'h04b0
`define FCL_HS_MAX_LIMIT    16'h0fa0
`define FCL_FREQ_LIMIT      16'h0fa0
`define FCL_VOLT_LIMIT      16'h03e8
`define FCL_CODE_OFF        16'h270f
`define FCL_CODE_95PCT      16'h22b8

`define FCL_RST_MAX_FREQ    16'h04b0
`define FCL_RST_MIN_FREQ    16'h0000
`define FCL_RST_JOG_FREQ    16'h0032
`define FCL_RST_START_FREQ  16'h0005
`define FCL_RST_BASE_FREQ   16'h0258
`define FCL_RST_RAMP_STEP   16'h0001

`define FCL_VMODE_SET       2'h0
`define FCL_VMODE_95PCT     2'h1
`define FCL_VMODE_FULL      2'h2

`define FCL_CLK_PERIOD_NS   5
`define FCL_RAMP_TICK_NS    10000
`define FCL_RAMP_TICK_CYC   (`FCL_RAMP_TICK_NS / `FCL_CLK_PERIOD_NS)

`endif

// ### rtl/fcl_ramp.v
// Frequency ramp: walks the output toward the target by a fixed step per tick.
// Assumes target and step are steady between ticks and come from the same clock.
`timescale 1ns/1ps
`include "fcl_defs.vh"
module fcl_ramp #(
    parameter FW = `FCL_FW
) (
    input  wire          hclk,       // System clock.
    input  wire          hresetn,    // Asynchronous reset, active low.
    input  wire          tick,       // One-cycle ramp update strobe.
    input  wire [FW-1:0] target,     // Steady frequency to reach.
    input  wire [FW-1:0] step,       // Change per tick.
    input  wire [FW-1:0] start_freq, // Lowest frequency to leave standstill.
    output reg  [FW-1:0] freq        // Ramped frequency.
);
    reg  [FW-1:0] next_freq;
    wire [FW:0]   up_sum = {1'b0, freq} + {1'b0, step};

    // Each tick moves by at most step, so bands are crossed, not skipped.
    always @* begin // (R10)
        next_freq = freq;
        if (target > freq) begin
            if (freq == {FW{1'b0}} && target < start_freq)
                next_freq = freq;
            else if (up_sum[FW] || up_sum[FW-1:0] > target)
                next_freq = target;
            else
                next_freq = up_sum[FW-1:0];
        end else if (target < freq) begin
            if (freq - target < step)
                next_freq = target;
            else
                next_freq = freq - step;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            freq <= {FW{1'b0}};
        else if (tick)
            freq <= next_freq;
    end
endmodule

// ### rtl/fcl_top.v
// Frequency command limiter: registers, clamping, jump bands, ramp, base selection.
// Assumes the command pins are asynchronous and quasi-static.
`timescale 1ns/1ps
`include "fcl_defs.vh"
module fcl_top #(
    parameter FW       = `FCL_FW,
    parameter NBANDS   = 3,
    parameter TICK_CYC = `FCL_RAMP_TICK_CYC
) (
    input  wire          hclk,        // System clock, 200 MHz.
    input  wire          hresetn,     // Asynchronous reset, active low.
    input  wire          hsel,        // Slave select.
    input  wire [31:0]   haddr,       // Byte address.
    input  wire [1:0]    htrans,      // Transfer type.
    input  wire          hwrite,      // Write when high.
    input  wire [2:0]    hsize,       // Transfer size.
    input  wire [31:0]   hwdata,      // Write data.
    input  wire          hready,      // Bus ready.
    output reg           hreadyout,   // Slave ready.
    output reg           hresp,       // Response, always OKAY.
    output reg  [31:0]   hrdata,      // Read data.
    input  wire [FW-1:0] freq_cmd,    // Frequency command pin, 0.1 Hz.
    input  wire          start,       // Start signal pin.
    input  wire          jog,         // Jog operation pin.
    input  wire          stall_active,// Stall prevention is lowering the frequency.
    input  wire [FW-1:0] stall_freq,  // Frequency demanded by stall prevention.
    input  wire          second_function_select, // Second function pin.
    input  wire          third_function_select,  // Third function pin.
    output reg  [FW-1:0] out_freq,    // Ramped output frequency, 0.1 Hz.
    output reg  [FW-1:0] out_target,  // Limited steady target, 0.1 Hz.
    output reg  [FW-1:0] out_base_freq, // Active base frequency, 0.1 Hz.
    output reg  [FW-1:0] out_base_volt, // Base voltage in volts when mode is set.
    output reg  [1:0]    out_volt_mode  // Base voltage mode.
);
    localparam [FW-1:0] ZERO = {FW{1'b0}};

    localparam [2:0] ST_STOP  = 3'b001;
    localparam [2:0] ST_RUN   = 3'b010;
    localparam [2:0] ST_STALL = 3'b100;
    reg  [2:0]    state;
    reg  [2:0]    next_state;
    reg  [FW-1:0] clamped;
    reg  [FW-1:0] max_output_freq;
    reg  [FW-1:0] min_output_freq;
    reg  [FW-1:0] jog_freq;
    reg  [FW-1:0] starting_freq;
    reg  [FW-1:0] base_freq;
    reg  [FW-1:0] base_voltage;
    reg  [FW-1:0] second_base_freq;
    reg  [FW-1:0] third_base_freq;
    reg  [FW-1:0] ramp_step;
    reg  [FW-1:0] jump_point [0:NBANDS-1];
    reg  [FW-1:0] jump_edge  [0:NBANDS-1];

    reg           wr_pend;
    reg  [7:0]    wr_addr;
    reg  [31:0]   next_rdata;
    wire [FW-1:0] wval = hwdata[FW-1:0];
    wire          addr_ok = hsel && hready && htrans[1];

    // Two-flop synchronisers for the pins.
    reg  [FW-1:0] cmd_m;
    reg  [FW-1:0] cmd_s;
    reg  [FW-1:0] stf_m;
    reg  [FW-1:0] stf_s;
    reg  [4:0]    pin_m;
    reg  [4:0]    pin_s;
    wire          start_s = pin_s[0];
    wire          jog_s   = pin_s[1];
    wire          stall_s = pin_s[2];
    wire          sel2_s  = pin_s[3];
    wire          sel3_s  = pin_s[4];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_m <= ZERO;
            cmd_s <= ZERO;
            stf_m <= ZERO;
            stf_s <= ZERO;
            pin_m <= 5'h00;
            pin_s <= 5'h00;
        end else begin
            cmd_m <= freq_cmd;
            cmd_s <= cmd_m;
            stf_m <= stall_freq;
            stf_s <= stf_m;
            pin_m <= {third_function_select, second_function_select, stall_active, jog, start};
            pin_s <= pin_m;
        end
    end

    function [FW-1:0] sat;
        input [FW-1:0] v;
        input [FW-1:0] lo;
        input [FW-1:0] hi;
        begin
            if (v < lo)
                sat = lo;
            else if (v > hi)
                sat = hi;
            else
                sat = v;
        end
    endfunction

    function [FW-1:0] freq_or_off;
        input [FW-1:0] v;
        begin
            if (v == `FCL_CODE_OFF)
                freq_or_off = v;
            else
                freq_or_off = sat(v, ZERO, `FCL_FREQ_LIMIT);
        end
    endfunction

    // Address phase is captured; writes complete in the data phase, no wait states.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= addr_ok && hwrite;
            wr_addr   <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    integer i;
    integer j;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            max_output_freq  <= `FCL_RST_MAX_FREQ;
            min_output_freq  <= `FCL_RST_MIN_FREQ; // (R3)
            jog_freq         <= `FCL_RST_JOG_FREQ;
            starting_freq    <= `FCL_RST_START_FREQ;
            base_freq        <= `FCL_RST_BASE_FREQ; // (R11)
            base_voltage     <= `FCL_CODE_OFF; // (R12)
            second_base_freq <= `FCL_CODE_OFF;
            third_base_freq  <= `FCL_CODE_OFF;
            ramp_step        <= `FCL_RST_RAMP_STEP;
            for (i = 0; i < NBANDS; i = i + 1) begin
                jump_point[i] <= `FCL_CODE_OFF; // (R7)
                jump_edge[i]  <= `FCL_CODE_OFF;
            end
        end else if (wr_pend) begin
            case (wr_addr)
                // One storage serves both offsets, so each write shows in the other.
                `FCL_OFS_MAX_FREQ:    max_output_freq <= sat(wval, ZERO, `FCL_MAX_LIMIT); // (R1) (R2)
                `FCL_OFS_HS_MAX_FREQ: max_output_freq <= sat(wval, `FCL_MAX_LIMIT, `FCL_HS_MAX_LIMIT); // (R2)
                `FCL_OFS_MIN_FREQ:    min_output_freq <= sat(wval, ZERO, `FCL_MAX_LIMIT);
                `FCL_OFS_JOG_FREQ:    jog_freq <= sat(wval, ZERO, `FCL_FREQ_LIMIT);
                `FCL_OFS_START_FREQ:  starting_freq <= sat(wval, ZERO, `FCL_FREQ_LIMIT);
                `FCL_OFS_BASE_FREQ:   base_freq <= sat(wval, ZERO, `FCL_FREQ_LIMIT); // (R11)
                `FCL_OFS_BASE2_FREQ:  second_base_freq <= freq_or_off(wval); // (R13)
                `FCL_OFS_BASE3_FREQ:  third_base_freq <= freq_or_off(wval); // (R14)
                `FCL_OFS_RAMP_STEP:   ramp_step <= (wval == ZERO) ? `FCL_RST_RAMP_STEP : wval;
                `FCL_OFS_BASE_VOLT: begin
                    if (wval == `FCL_CODE_OFF || wval == `FCL_CODE_95PCT)
                        base_voltage <= wval; // (R12)
                    else
                        base_voltage <= sat(wval, ZERO, `FCL_VOLT_LIMIT);
                end
                default: begin
                    for (i = 0; i < NBANDS; i = i + 1) begin
                        if (wr_addr == `FCL_OFS_JUMP_BASE + i[7:0] * 8'h08)
                            jump_point[i] <= freq_or_off(wval); // (R7)
                        if (wr_addr == `FCL_OFS_JUMP_BASE + i[7:0] * 8'h08 + 8'h04)
                            jump_edge[i] <= freq_or_off(wval);
                    end
                end
            endcase
        end
    end

    // Read data is looked up in the address phase and registered for the data phase.
    always @* begin
        next_rdata = 32'h00000000;
        case (haddr[7:0])
            `FCL_OFS_MAX_FREQ:    next_rdata[FW-1:0] = max_output_freq;
            `FCL_OFS_HS_MAX_FREQ: next_rdata[FW-1:0] = max_output_freq;
            `FCL_OFS_MIN_FREQ:    next_rdata[FW-1:0] = min_output_freq;
            `FCL_OFS_JOG_FREQ:    next_rdata[FW-1:0] = jog_freq;
            `FCL_OFS_START_FREQ:  next_rdata[FW-1:0] = starting_freq;
            `FCL_OFS_BASE_FREQ:   next_rdata[FW-1:0] = base_freq;
            `FCL_OFS_BASE_VOLT:   next_rdata[FW-1:0] = base_voltage;
            `FCL_OFS_BASE2_FREQ:  next_rdata[FW-1:0] = second_base_freq;
            `FCL_OFS_BASE3_FREQ:  next_rdata[FW-1:0] = third_base_freq;
            `FCL_OFS_RAMP_STEP:   next_rdata[FW-1:0] = ramp_step;
            `FCL_OFS_STATUS:      next_rdata = {out_target, out_freq};
            `FCL_OFS_BASE_STAT:   next_rdata = {11'h000, state, out_volt_mode, out_base_freq};
            default: begin
                for (j = 0; j < NBANDS; j = j + 1) begin
                    if (haddr[7:0] == `FCL_OFS_JUMP_BASE + j[7:0] * 8'h08)
                        next_rdata[FW-1:0] = jump_point[j];
                    if (haddr[7:0] == `FCL_OFS_JUMP_BASE + j[7:0] * 8'h08 + 8'h04)
                        next_rdata[FW-1:0] = jump_edge[j];
                end
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (addr_ok && !hwrite)
            hrdata <= next_rdata;
    end

    // Command conditioning, in order: source select, limits, then jump bands.
    always @* begin
        next_state = state;
        case (state)
            ST_STOP: begin
                if (stall_s && (start_s || jog_s))
                    next_state = ST_STALL;
                else if (start_s || jog_s)
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (!(start_s || jog_s))
                    next_state = ST_STOP;
                else if (stall_s)
                    next_state = ST_STALL;
            end
            ST_STALL: begin
                if (!(start_s || jog_s))
                    next_state = ST_STOP;
                else if (!stall_s)
                    next_state = ST_RUN;
            end
            default: next_state = ST_STOP;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            state <= ST_STOP;
        else
            state <= next_state;
    end

    always @* begin
        clamped = ZERO;
        if (jog_s) begin
            // Jog bypasses the lower limit, only the maximum still applies.
            clamped = (jog_freq > max_output_freq) ? max_output_freq : jog_freq; // (R4)
        end else if (cmd_s > max_output_freq) begin
            clamped = max_output_freq; // (R1) (R15)
        end else if (cmd_s < min_output_freq) begin
            // A zero command with start on still yields the minimum.
            clamped = min_output_freq; // (R3) (R6)
        end else begin
            clamped = cmd_s;
        end
    end

    // Jump bands chained in order; band 0 sees the clamped value first.
    wire [FW-1:0] chain [0:NBANDS];
    assign chain[0] = clamped;
    genvar g;
    generate
        for (g = 0; g < NBANDS; g = g + 1) begin : band
            wire [FW-1:0] pt  = jump_point[g];
            wire [FW-1:0] eg  = jump_edge[g];
            wire          on  = (pt != `FCL_CODE_OFF) && (eg != `FCL_CODE_OFF); // (R7)
            wire [FW-1:0] lo  = (pt < eg) ? pt : eg;
            wire [FW-1:0] hi  = (pt < eg) ? eg : pt;
            wire          hit = on && chain[g] >= lo && chain[g] <= hi;
            // The first-of-pair wins whether it is the low or the high edge.
            assign chain[g+1] = hit ? pt : chain[g]; // (R8) (R9) (R15)
        end
    endgenerate

    reg [FW-1:0] next_target;
    always @* begin
        case (state)
            ST_RUN:   next_target = chain[NBANDS]; // (R15)
            // Stall prevention takes the lower of stf_s and the limited target, below the minimum if it must.
            ST_STALL: next_target = (stf_s < chain[NBANDS]) ? stf_s : chain[NBANDS]; // (R5)
            default:  next_target = ZERO;
        endcase
    end

    reg [12:0] tick_cnt;
    reg        tick;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= 13'h0000;
            tick     <= 1'b0;
        end else if (tick_cnt == TICK_CYC[12:0] - 13'h0001) begin
            tick_cnt <= 13'h0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 13'h0001;
            tick     <= 1'b0;
        end
    end

    wire [FW-1:0] ramp_freq;
    // The ramp climbs step by step to the target, which covers start-to-minimum too.
    fcl_ramp #(
        .FW(FW)
    ) u_ramp (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .tick       (tick),
        .target     (out_target),
        .step       (ramp_step),
        .start_freq (starting_freq),
        .freq       (ramp_freq)
    ); // (R6) (R10)

    reg [FW-1:0] next_base;
    reg [1:0]    next_vmode;
    always @* begin
        next_base = base_freq; // (R11)
        if (sel3_s && third_base_freq != `FCL_CODE_OFF)
            next_base = third_base_freq; // (R14)
        else if (sel2_s && second_base_freq != `FCL_CODE_OFF)
            next_base = second_base_freq; // (R13)
        if (base_voltage == `FCL_CODE_OFF)
            next_vmode = `FCL_VMODE_FULL; // (R12)
        else if (base_voltage == `FCL_CODE_95PCT)
            next_vmode = `FCL_VMODE_95PCT;
        else
            next_vmode = `FCL_VMODE_SET;
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_target    <= ZERO;
            out_freq      <= ZERO;
            out_base_freq <= `FCL_RST_BASE_FREQ;
            out_base_volt <= ZERO;
            out_volt_mode <= `FCL_VMODE_FULL;
        end else begin
            out_target    <= next_target;
            out_freq      <= ramp_freq;
            out_base_freq <= next_base;
            out_base_volt <= (next_vmode == `FCL_VMODE_SET) ? base_voltage : ZERO;
            out_volt_mode <= next_vmode;
        end
    end
endmodule

// ### tb/fcl_assertions.sv
// Concurrent checks on the limiter's top-level ports.
// Assumes the one hclk domain and asynchronous active-low hresetn.
`timescale 1ns/1ps
`include "fcl_defs.vh"
module fcl_chk #(
    parameter FW       = 16,
    parameter TICK_CYC = 2000
) (
    input wire          hclk,          // System clock.
    input wire          hresetn,       // Reset, active low.
    input wire          hsel,          // Slave select.
    input wire [31:0]   haddr,         // Byte address.
    input wire [1:0]    htrans,        // Transfer type.
    input wire          hwrite,        // Write when high.
    input wire          hready,        // Bus ready.
    input wire          hreadyout,     // Slave ready.
    input wire          hresp,         // Response.
    input wire [31:0]   hrdata,        // Read data.
    input wire          start,         // Start pin.
    input wire          jog,           // Jog pin.
    input wire [FW-1:0] out_freq,      // Ramped frequency.
    input wire [FW-1:0] out_target,    // Steady target.
    input wire [FW-1:0] out_base_freq, // Active base frequency.
    input wire [FW-1:0] out_base_volt, // Base voltage.
    input wire [1:0]    out_volt_mode  // Base voltage mode.
);
    localparam [15:0] TICK16 = TICK_CYC;
    reg [15:0] since_chg;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Counts cycles since the ramp output last moved, saturating at one tick.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            since_chg <= TICK16;
        end else if ($changed(out_freq)) begin
            since_chg <= 16'h0001;
        end else if (since_chg < TICK16) begin
            since_chg <= since_chg + 16'h0001;
        end
    end

    sequence s_no_run;
        (!start && !jog) [*5];
    endsequence
    sequence s_rd_unmapped;
        hsel && hready && htrans[1] && !hwrite && (haddr[7:0] > 8'h44);
    endsequence

    a_bus_okay:     assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
    a_rd_unmapped:  assert property (s_rd_unmapped |=> hrdata == 32'h0) else $error("unmapped read not zero");
    a_idle_target:  assert property (s_no_run |-> out_target == 16'h0000) else $error("target without run");
    a_freq_pace:    assert property ($changed(out_freq) |-> since_chg >= TICK16) else $error("ramp too fast");
    a_target_cap:   assert property (out_target <= `FCL_HS_MAX_LIMIT) else $error("target above cap");
    a_freq_cap:     assert property (out_freq <= `FCL_HS_MAX_LIMIT) else $error("output above cap");
    a_base_cap:     assert property (out_base_freq <= `FCL_FREQ_LIMIT) else $error("base above range");
    a_volt_cap:     assert property (out_volt_mode == `FCL_VMODE_SET |-> out_base_volt <= `FCL_VOLT_LIMIT)
                        else $error("base voltage above range");
    a_volt_code:    assert property (out_volt_mode != `FCL_VMODE_SET |-> out_base_volt == 16'h0000 &&
                        out_volt_mode != 2'h3) else $error("bad voltage code");
endmodule

bind fcl_top fcl_chk #(.FW(FW), .TICK_CYC(TICK_CYC)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .start(start), .jog(jog),
    .out_freq(out_freq), .out_target(out_target), .out_base_freq(out_base_freq),
    .out_base_volt(out_base_volt), .out_volt_mode(out_volt_mode)
);

// ### tb/fcl_cmd_src.sv
// Command source model: command, start, jog, stall and select levels.
// Assumes the bench steps it; levels change just after a rising edge.
`timescale 1ns/1ps
module fcl_cmd_src (
    input  wire        hclk,         // System clock.
    output reg  [15:0] freq_cmd,     // Frequency command.
    output reg         start,        // Start level.
    output reg         jog,          // Jog level.
    output reg         stall_active, // Stall prevention active.
    output reg  [15:0] stall_freq,   // Stall demanded frequency.
    output reg         sel2,         // Second function select.
    output reg         sel3          // Third function select.
);
    initial begin
        {freq_cmd, start, jog, stall_active, stall_freq, sel2, sel3} = 37'h0;
    end

    task drive(input [15:0] c, input s, input j, input sa, input [15:0] sf, input s2, input s3);
        @(posedge hclk);
        freq_cmd     <= c;
        start        <= s;
        jog          <= j;
        stall_active <= sa;
        stall_freq   <= sf;
        sel2         <= s2;
        sel3         <= s3;
    endtask
endmodule

// ### tb/fcl_top_tb.sv
// Self-checking bench of the limiter: bus, clamping, jump bands, ramp, base selection.
// Assumes the command source model and the bound checker; ramp tick cut to four cycles.
`timescale 1ns/1ps
`include "fcl_defs.vh"
`define FCL_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    $display("ERROR %s expected %h seen %h", nm, e, g); err_count++; end end
module fcl_top_tb;
    reg         hclk, hresetn, hsel, hwrite;
    reg  [31:0] haddr, hwdata, rd;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    wire        hreadyout, hresp, start, jog, stall_active, sel2, sel3;
    wire        hready = hreadyout;
    wire [31:0] hrdata;
    wire [15:0] freq_cmd, stall_freq, out_freq, out_target, out_base_freq, out_base_volt;
    wire [1:0]  out_volt_mode;
    integer     err_count, comparisons, i, n;
    reg         seen;

    fcl_top #(.TICK_CYC(4)) dut (.*, .second_function_select(sel2), .third_function_select(sel3));
    fcl_cmd_src src (.*);

    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    task conclude;
        if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Address phase held until hready, then the data phase until hready again.
    task bus(input wr, input [31:0] a, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= wr; hsize <= 3'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0; hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task wr(input [31:0] a, input [31:0] d); bus(1'b1, a, d); endtask
    task rchk(input string nm, input [31:0] a, input [31:0] e); bus(1'b0, a, 32'h0); `FCL_CHK(nm, e, rd) endtask
    task tgt(input string nm, input [15:0] e); repeat (6) @(posedge hclk); `FCL_CHK(nm, e, out_target) endtask
    task run(input [15:0] c, input s); src.drive(c, s, 1'b0, 1'b0, 16'h0, 1'b0, 1'b0); endtask
    task idle; tgt("idle_tgt", 16'h0000); endtask
    task wait_freq(input [15:0] e);
        for (n = 0; n < 3000 && out_freq !== e; n++) @(posedge hclk);
    endtask

    task t_resets;
        `FCL_CHK("base_out", 16'h0258, out_base_freq)
        `FCL_CHK("vmode_rst", `FCL_VMODE_FULL, out_volt_mode)
        rchk("max", 32'h00, 32'h04b0);
        rchk("min", 32'h04, 32'h0000);
        rchk("jogf", 32'h0c, 32'h0032);
        rchk("startf", 32'h10, 32'h0005);
        for (i = 0; i < 6; i++) rchk("band", 32'h14 + 4 * i, 32'h270f);
        rchk("base", 32'h2c, 32'h0258);
        rchk("bvolt", 32'h30, 32'h270f);
        rchk("base2", 32'h34, 32'h270f);
        rchk("base3", 32'h38, 32'h270f);
        rchk("unmapped", 32'h48, 32'h0);
    endtask

    task t_max;
        wr(32'h3c, 32'h000a);
        wr(32'h08, 32'h07d0);
        rchk("max_link", 32'h00, 32'h07d0);
        wr(32'h00, 32'h0384);
        rchk("hs_link", 32'h08, 32'h0384);
        run(16'h05dc, 1'b1);
        tgt("clamp_max", 16'h0384);
        wr(32'h40, 32'hffff);
        bus(1'b0, 32'h40, 32'h0);
        `FCL_CHK("status_tgt", 16'h0384, rd[31:16])
        wr(32'h00, 32'h1388);
        rchk("max_sat", 32'h00, 32'h04b0);
        wr(32'h08, 32'h2328);
        rchk("hs_sat", 32'h00, 32'h0fa0);
        wr(32'h00, 32'h04b0);
    endtask

    task t_min_jog_stall;
        wr(32'h04, 32'h0064);
        run(16'h0032, 1'b1);
        tgt("clamp_min", 16'h0064);
        run(16'h0000, 1'b1);
        tgt("start_min", 16'h0064);
        wait_freq(16'h0064);
        `FCL_CHK("ramp_min", 16'h0064, out_freq)
        src.drive(16'h0000, 1'b0, 1'b1, 1'b0, 16'h0, 1'b0, 1'b0);
        tgt("jog_low", 16'h0032);
        wr(32'h0c, 32'h0096);
        tgt("jog_high", 16'h0096);
        src.drive(16'h01f4, 1'b1, 1'b0, 1'b1, 16'h001e, 1'b0, 1'b0);
        tgt("stall_low", 16'h001e);
        wr(32'h04, 32'h0000);
    endtask

    task t_jump;
        run(16'h0140, 1'b1);
        for (i = 0; i < 3; i++) begin
            wr(32'h14 + 8 * i, 32'h012c);
            wr(32'h18 + 8 * i, 32'h015e);
            tgt("band_hold", 16'h012c);
            wr(32'h14 + 8 * i, 32'h270f);
            tgt("band_off", 16'h0140);
            wr(32'h18 + 8 * i, 32'h270f);
        end
        wr(32'h14, 32'h015e);
        wr(32'h18, 32'h012c);
        tgt("band_swap", 16'h015e);
        run(16'h0122, 1'b1);
        tgt("band_out", 16'h0122);
        wr(32'h00, 32'h014a);
        wr(32'h14, 32'h0154);
        wr(32'h18, 32'h0140);
        run(16'h0190, 1'b1);
        tgt("clamp_then_jump", 16'h0154);
        wr(32'h00, 32'h04b0);
    endtask

    task t_ramp_through;
        run(16'h0000, 1'b0);
        wait_freq(16'h0000);
        wr(32'h14, 32'h012c);
        wr(32'h18, 32'h015e);
        seen = 1'b0;
        run(16'h0190, 1'b1);
        for (n = 0; n < 3000 && out_freq !== 16'h0190; n++) begin
            @(posedge hclk);
            if (out_freq > 16'h012c && out_freq < 16'h015e) seen = 1'b1;
        end
        `FCL_CHK("ramp_in_band", 1'b1, seen)
        `FCL_CHK("ramp_end", 16'h0190, out_freq)
    endtask

    task t_base;
        run(16'h0000, 1'b0);
        wr(32'h30, 32'h03e8);
        idle;
        `FCL_CHK("vmode_set", `FCL_VMODE_SET, out_volt_mode)
        `FCL_CHK("volt_set", 16'h03e8, out_base_volt)
        wr(32'h30, 32'h22b8);
        idle;
        `FCL_CHK("vmode_95", `FCL_VMODE_95PCT, out_volt_mode)
        wr(32'h30, 32'h270f);
        wr(32'h2c, 32'h01f4);
        wr(32'h34, 32'h02ee);
        wr(32'h38, 32'h0384);
        idle;
        `FCL_CHK("vmode_full", `FCL_VMODE_FULL, out_volt_mode)
        `FCL_CHK("base_new", 16'h01f4, out_base_freq)
        src.drive(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0, 1'b1, 1'b0);
        idle;
        `FCL_CHK("base_sel2", 16'h02ee, out_base_freq)
        src.drive(16'h0000, 1'b0, 1'b0, 1'b0, 16'h0, 1'b1, 1'b1);
        idle;
        `FCL_CHK("base_sel3", 16'h0384, out_base_freq)
        wr(32'h38, 32'h270f);
        idle;
        `FCL_CHK("base3_off", 16'h02ee, out_base_freq)
        wr(32'h34, 32'h270f);
        idle;
        `FCL_CHK("base2_off", 16'h01f4, out_base_freq)
    endtask

    // A hang anywhere ends the run here, counted as a mismatch.
    initial begin
        #200000;
        err_count++;
        conclude;
    end

    initial begin
        hresetn = 1'b0; hsel = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; rd = 32'h0; seen = 1'b0; err_count = 0; comparisons = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_resets;
        t_max;
        t_min_jog_stall;
        t_jump;
        t_ramp_through;
        t_base;
        conclude;
    end
endmodule
